// File: rtl/drive_cmd.sv
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "drive_cmd_consts.svh"
module drive_cmd
	import drive_cmd_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// contacts and analogue samples
	input wire logic first_contact_input_i,
	input wire logic second_contact_input_i,
	input wire logic programmable_contact_input_i,
	input wire logic [`ADC_W-1:0] vin_i,
	input wire logic [`ADC_W-1:0] iin_i,
	// drive commands and limits
	output cmd_t cmd_o,
	output lim_t lim_o,
	// axi4-lite slave
	input wire logic [7:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [7:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i
);

	function automatic [11:0] span(input [11:0] x, input [11:0] lo, input [11:0] hi);
		logic [23:0] t;
		t = '0;
		if (hi <= lo)
			span = (x >= hi) ? `ADC_FULL : 12'h000;
		else if (x <= lo)
			span = 12'h000;
		else if (x >= hi)
			span = `ADC_FULL;
		else
		begin
			t = ((x - lo) * `ADC_FULL) / {12'h000, hi - lo};
			span = t[11:0];
		end
	endfunction

	function automatic [15:0] scale(input [11:0] p, input [31:0] s, input [15:0] fmax);
		logic [27:0] t;
		t = '0;
		if (s[31:16] != 16'h0000 && s[15:0] != 16'h0000 && s[15:0] < s[31:16]
			&& s[31:16] < fmax)
		begin
			t = (s[31:16] - s[15:0]) * p;
			scale = s[15:0] + t[27:12];
		end
		else
		begin
			t = fmax * p;
			scale = t[27:12];
		end
	endfunction

	function automatic [15:0] reduce(input [15:0] v, input [11:0] p);
		logic [27:0] t;
		t = v * p;
		reduce = t[27:12];
	endfunction

	function automatic [31:0] merge(input [31:0] o, input [31:0] d, input [3:0] b);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = b[i] ? d[i*8 +: 8] : o[i*8 +: 8];
	endfunction

	state_t s, n;
	logic [2:0] c;
	logic [2:0] rise;
	scheme_t eff;
	func_t fn;
	logic ext_now, gate;
	logic [11:0] pv, pi, pf;
	logic [31:0] floor_w;
	logic [15:0] floor16;

	assign c = s.sync2;
	assign rise = s.sync2 & ~s.prev;
	assign fn = func_t'(s.ctrl[`C_FN_HI:`C_FN_LO]);
	always_comb
	begin
		eff = scheme_t'(s.ctrl[`C_SCH_HI:`C_SCH_LO]);
		if (s.ctrl[`C_SRC_HI:`C_SRC_LO] >= `SRC_MPOT)
			eff = SCH_MPOT;
	end
	assign ext_now = (fn == F_FLT_CLOSE && c[2]) || (fn == F_FLT_OPEN && !c[2]);
	assign gate = !s.cmd.fault && !ext_now && (fn != F_RUN_EN || c[2] || s.cmd.run);

	// analogue conditioning
	always_comb
	begin
		pv = s.ctrl[`C_VRNG] ? span(vin_i, s.vmin, s.vmax) : vin_i;
		if (s.ctrl[`C_IRNG_HI:`C_IRNG_LO] == 2'h1)
			pi = span(iin_i, `ADC_4MA, `ADC_FULL);
		else if (s.ctrl[`C_IRNG_HI:`C_IRNG_LO] == 2'h2)
			pi = span(iin_i, s.imin, s.imax);
		else
			pi = iin_i;
		if (s.ctrl[`C_VINV])
			pv = `ADC_FULL - pv;
		if (s.ctrl[`C_IINV])
			pi = `ADC_FULL - pi;
		if (s.ctrl[`C_FSEL_HI:`C_FSEL_LO] == 2'h1)
			pf = pv;
		else if (s.ctrl[`C_FSEL_HI:`C_FSEL_LO] == 2'h2)
			pf = pi;
		else
			pf = `ADC_FULL;
	end
	assign floor_w = {16'h0000, s.lim1[15:0]} * `BRK_FLOOR_NUM / `BRK_FLOOR_DEN;
	assign floor16 = floor_w[15:0];

	always_comb
	begin
		n = s;
		n.sync1 = {programmable_contact_input_i, second_contact_input_i,
			first_contact_input_i};
		n.sync2 = s.sync1;
		n.prev = s.sync2;
		n.cmd.up = 1'b0;
		case (eff)
			SCH_FWD_REV:
			begin
				n.cmd.run = c[0] | c[1];
				if (c[0] && c[1])
				begin
					if (s.prev[1:0] == 2'b10)
						n.cmd.rev = 1'b1;
					else if (s.prev[1:0] == 2'b11)
						n.cmd.rev = s.cmd.rev;
					else
						n.cmd.rev = 1'b0;
				end
				else
					n.cmd.rev = c[1];
			end
			SCH_RUN_DIR:
			begin
				n.cmd.run = c[0];
				n.cmd.rev = c[1];
			end
			SCH_RUN_EN:
			begin
				n.cmd.run = c[0] && (s.cmd.run || c[1]);
				n.cmd.rev = 1'b0;
			end
			SCH_PULSE:
			begin
				if (rise[1])
					n.cmd.run = 1'b0;
				else if (rise[0])
					n.cmd.run = 1'b1;
				n.cmd.rev = (fn == F_REVERSE) && c[2];
			end
			SCH_MPOT:
			begin
				n.cmd.run = c[0];
				n.cmd.rev = 1'b0;
				n.cmd.up = c[1];
			end
			default:
			begin
				n.cmd.run = 1'b0;
				n.cmd.rev = 1'b0;
			end
		endcase
		if (fn == F_RUN_EN && !c[2] && !s.cmd.run)
			n.cmd.run = 1'b0;
		n.cmd.fault_rst = (fn == F_FLT_RST) && c[2];
		if (n.cmd.fault_rst)
			n.cmd.fault = 1'b0;
		if (ext_now)
			n.cmd.fault = 1'b1;
		if (n.cmd.fault)
			n.cmd.run = 1'b0;
		n.cmd.ramp2 = (fn == F_RAMP_SEL) && c[2];
		n.cmd.jog = (fn == F_JOG) && c[2];
		n.cmd.hold = (fn == F_RAMP_HOLD) && c[2];
		n.cmd.brake = (fn == F_DC_BRAKE) && c[2] && !n.cmd.run;
		n.cmd.down = (fn == F_MPOT_DN) && c[2];

		// reference and reduced limits
		if (s.ctrl[`C_SRC_HI:`C_SRC_LO] == 3'h0)
			n.lim.ref_val = scale(pi, s.scale_a, s.fmax);
		else
			n.lim.ref_val = scale(pv, s.scale_b, s.fmax);
		n.lim.cur_lim = s.lim0[15:0];
		n.lim.brk_cur = s.lim0[31:16];
		n.lim.trq_lim = s.lim1[31:16];
		n.lim.ramp_div = 3'h1;
		case (s.ctrl[`C_FFN_HI:`C_FFN_LO])
			3'h1: n.lim.cur_lim = reduce(s.lim0[15:0], pf);
			3'h2:
				if (s.lim0[31:16] > floor16)
					n.lim.brk_cur = floor16 + reduce(s.lim0[31:16] - floor16, pf);
			3'h3: n.lim.ramp_div = 3'h1 + {1'b0, pf[11:10]};
			3'h4: n.lim.trq_lim = reduce(s.lim1[31:16], pf);
			default: n.lim.ramp_div = 3'h1;
		endcase

		// write channel
		if (s.awready && awvalid_i)
		begin
			n.aw_got = 1'b1;
			n.waddr = awaddr_i;
		end
		if (s.wready && wvalid_i)
		begin
			n.w_got = 1'b1;
			n.wdata = wdata_i;
			n.wstrb = wstrb_i;
		end
		if (s.bvalid && bready_i)
			n.bvalid = 1'b0;
		if (s.aw_got && s.w_got && !s.bvalid)
		begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `RESP_OK;
			if (s.waddr == `A_CTRL)
				n.ctrl = 20'(merge({12'h000, s.ctrl}, s.wdata, s.wstrb));
			else if (s.waddr == `A_CAP)
			begin
				if (s.wstrb[0] && s.wdata[0])
					n.vmin = vin_i;
				if (s.wstrb[0] && s.wdata[1])
					n.vmax = vin_i;
				if (s.wstrb[0] && s.wdata[2])
					n.imin = iin_i;
				if (s.wstrb[0] && s.wdata[3])
					n.imax = iin_i;
			end
			else if (s.waddr == `A_VSPAN || s.waddr == `A_ISPAN || s.waddr == `A_REF)
				n.bresp = `RESP_OK;
			else if (s.waddr == `A_SCALE_A)
				n.scale_a = merge(s.scale_a, s.wdata, s.wstrb);
			else if (s.waddr == `A_SCALE_B)
				n.scale_b = merge(s.scale_b, s.wdata, s.wstrb);
			else if (s.waddr == `A_FMAX)
				n.fmax = 16'(merge({16'h0000, s.fmax}, s.wdata, s.wstrb));
			else if (s.waddr == `A_LIM0)
				n.lim0 = merge(s.lim0, s.wdata, s.wstrb);
			else if (s.waddr == `A_LIM1)
				n.lim1 = merge(s.lim1, s.wdata, s.wstrb);
			else if (s.waddr == `A_STATUS)
			begin
				if (s.wstrb[0] && s.wdata[0] && !ext_now)
					n.cmd.fault = 1'b0;
			end
			else
				n.bresp = `RESP_ERR;
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;

		// read channel
		if (s.rvalid && rready_i)
			n.rvalid = 1'b0;
		if (s.arready && arvalid_i)
		begin
			n.rvalid = 1'b1;
			n.rresp = `RESP_OK;
			n.rdata = 32'h00000000;
			if (araddr_i == `A_CTRL)
				n.rdata = {12'h000, s.ctrl};
			else if (araddr_i == `A_CAP)
				n.rdata = 32'h00000000;
			else if (araddr_i == `A_VSPAN)
				n.rdata = {4'h0, s.vmax, 4'h0, s.vmin};
			else if (araddr_i == `A_ISPAN)
				n.rdata = {4'h0, s.imax, 4'h0, s.imin};
			else if (araddr_i == `A_SCALE_A)
				n.rdata = s.scale_a;
			else if (araddr_i == `A_SCALE_B)
				n.rdata = s.scale_b;
			else if (araddr_i == `A_FMAX)
				n.rdata = {16'h0000, s.fmax};
			else if (araddr_i == `A_LIM0)
				n.rdata = s.lim0;
			else if (araddr_i == `A_LIM1)
				n.rdata = s.lim1;
			else if (araddr_i == `A_STATUS)
				n.rdata = {19'h00000, c, s.cmd};
			else if (araddr_i == `A_REF)
				n.rdata = {16'h0000, s.lim.ref_val};
			else
				n.rresp = `RESP_ERR;
		end
		n.arready = !n.rvalid;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s <= '0;
			s.fmax <= `FMAX_RST;
			s.vmax <= `ADC_FULL;
			s.imax <= `ADC_FULL;
		end
		else
			s <= n;
	end

	assign cmd_o = s.cmd;
	assign lim_o = s.lim;
	assign awready_o = s.awready;
	assign wready_o = s.wready;
	assign bvalid_o = s.bvalid;
	assign bresp_o = s.bresp;
	assign arready_o = s.arready;
	assign rvalid_o = s.rvalid;
	assign rdata_o = s.rdata;
	assign rresp_o = s.rresp;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_s0_fwd;
		(eff == SCH_FWD_REV && c[1:0] == 2'b01 && gate) |=> cmd_o.run && !cmd_o.rev;
	endproperty
	a_s0_fwd: assert property (p_s0_fwd) else $error("forward start not obeyed");
	property p_s0_first;
		(eff == SCH_FWD_REV && c[1:0] == 2'b11 && s.prev[1:0] == 2'b11 && gate)
			|=> cmd_o.rev == $past(s.cmd.rev);
	endproperty
	a_s0_first: assert property (p_s0_first) else $error("first direction lost");
	property p_s0_both;
		(eff == SCH_FWD_REV && c[1:0] == 2'b11 && s.prev[1:0] == 2'b00 && gate)
			|=> cmd_o.run && !cmd_o.rev;
	endproperty
	a_s0_both: assert property (p_s0_both) else $error("simultaneous start not forward");
	property p_s0_change;
		(eff == SCH_FWD_REV && c[1:0] == 2'b10 && s.prev[1:0] == 2'b11 && gate) |=> cmd_o.rev;
	endproperty
	a_s0_change: assert property (p_s0_change) else $error("direction did not change");
	property p_s1;
		(eff == SCH_RUN_DIR && gate) |=> cmd_o.run == $past(c[0]) && cmd_o.rev == $past(c[1]);
	endproperty
	a_s1: assert property (p_s1) else $error("scheme 1 mismatch");
	property p_s3_stop;
		(eff == SCH_PULSE && rise[1]) |=> !cmd_o.run ##1 (!cmd_o.run || $past(rise[0]));
	endproperty
	a_s3_stop: assert property (p_s3_stop) else $error("stop pulse ignored");
	property p_mpot;
		(s.ctrl[`C_SRC_HI:`C_SRC_LO] >= `SRC_MPOT) |=> cmd_o.up == $past(c[1]);
	endproperty
	a_mpot: assert property (p_mpot) else $error("pot raise not forced");
	property p_ext;
		ext_now |=> cmd_o.fault && !cmd_o.run;
	endproperty
	a_ext: assert property (p_ext) else $error("external fault missed");
	property p_ramp;
		(fn == F_RAMP_SEL) |=> cmd_o.ramp2 == $past(c[2]);
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp set wrong");
	property p_brake;
		(fn == F_DC_BRAKE && c[2] && !s.cmd.run && eff == SCH_FWD_REV && c[1:0] == 2'b00)
			|=> cmd_o.brake;
	endproperty
	a_brake: assert property (p_brake) else $error("dc brake missing");
	property p_bhold;
		bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	c_dir: cover property (eff == SCH_FWD_REV && c[1:0] == 2'b10 ##1 cmd_o.rev);
	c_latch: cover property (eff == SCH_PULSE && rise[0] ##1 cmd_o.run);
	c_fault: cover property (cmd_o.fault ##[1:20] !cmd_o.fault);
endmodule

// File: rtl/drive_cmd_consts.svh
`ifndef DRIVE_CMD_CONSTS_SVH
`define DRIVE_CMD_CONSTS_SVH
// register byte addresses
`define A_CTRL 8'h00
`define A_CAP 8'h04
`define A_VSPAN 8'h08
`define A_ISPAN 8'h0C
`define A_SCALE_A 8'h10
`define A_SCALE_B 8'h14
`define A_FMAX 8'h18
`define A_LIM0 8'h1C
`define A_LIM1 8'h20
`define A_STATUS 8'h24
`define A_REF 8'h28
// control field positions
`define C_SCH_HI 2
`define C_SCH_LO 0
`define C_FN_HI 6
`define C_FN_LO 3
`define C_SRC_HI 9
`define C_SRC_LO 7
`define C_VRNG 10
`define C_IRNG_HI 12
`define C_IRNG_LO 11
`define C_VINV 13
`define C_IINV 14
`define C_FSEL_HI 16
`define C_FSEL_LO 15
`define C_FFN_HI 19
`define C_FFN_LO 17
// widths, codes and reset values
`define ADC_W 12
`define ADC_FULL 12'hFFF
`define ADC_4MA 12'h333
`define SRC_MPOT 3'h3
`define FMAX_RST 16'h01F4
`define BRK_FLOOR_NUM 32'h0000000F
`define BRK_FLOOR_DEN 32'h00000064
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// File: rtl/drive_cmd_pkg.sv
package drive_cmd_pkg;
`include "drive_cmd_consts.svh"
typedef enum logic [2:0] {
	SCH_FWD_REV = 3'h0,
	SCH_RUN_DIR = 3'h1,
	SCH_RUN_EN = 3'h2,
	SCH_PULSE = 3'h3,
	SCH_MPOT = 3'h4
} scheme_t;
typedef enum logic [3:0] {
	F_NONE = 4'h0, F_FLT_CLOSE = 4'h1, F_FLT_OPEN = 4'h2, F_RUN_EN = 4'h3,
	F_RAMP_SEL = 4'h4, F_REVERSE = 4'h5, F_JOG = 4'h6, F_FLT_RST = 4'h7,
	F_RAMP_HOLD = 4'h8, F_DC_BRAKE = 4'h9, F_MPOT_DN = 4'hA
} func_t;
typedef struct packed {
	logic run, rev, fault, fault_rst, ramp2, jog, hold, brake, up, down;
} cmd_t;
typedef struct packed {
	logic [15:0] ref_val, cur_lim, brk_cur, trq_lim;
	logic [2:0] ramp_div;
} lim_t;
typedef struct packed {
	logic [2:0] sync1, sync2, prev;
	logic [19:0] ctrl;
	logic [`ADC_W-1:0] vmin, vmax, imin, imax;
	logic [31:0] scale_a, scale_b, lim0, lim1;
	logic [15:0] fmax;
	cmd_t cmd;
	lim_t lim;
	logic aw_got, w_got;
	logic [7:0] waddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
} state_t;
endpackage

// File: tb/contact_src.sv
`timescale 1ns/1ps
`include "drive_cmd_consts.svh"
module contact_src
	import drive_cmd_pkg::*;
(
	// clock
	input wire logic clk_i,
	// contacts and samples toward the drive
	output logic first_contact_input_o,
	output logic second_contact_input_o,
	output logic programmable_contact_input_o,
	output logic [`ADC_W-1:0] vin_o,
	output logic [`ADC_W-1:0] iin_o
);
	logic [2:0] c_reg = 3'h0;
	logic [`ADC_W-1:0] v_reg = 12'h000;
	logic [`ADC_W-1:0] i_reg = 12'h000;
	assign {programmable_contact_input_o, second_contact_input_o, first_contact_input_o} = c_reg;
	// levels hold until changed, so a capture sees the live input
	assign vin_o = v_reg;
	assign iin_o = i_reg;
	// d extra cycles model a slow switch
	task set_c(input logic [2:0] c, input int d);
		repeat (d) @(posedge clk_i);
		c_reg <= c;
	endtask
	task set_adc(input logic [`ADC_W-1:0] v, input logic [`ADC_W-1:0] i);
		v_reg <= v;
		i_reg <= i;
	endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`include "drive_cmd_consts.svh"
module tb
	import drive_cmd_pkg::*;
();
	localparam logic [9:0] RUN = 10'h200, REV = 10'h100, FLT = 10'h080, UP = 10'h002;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic c1, c2, c3, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [11:0] vin, iin;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp, r;
	logic [15:0] rnd = 16'h002D;
	cmd_t cmd;
	lim_t lim;
	int err_count = 0, n_checks = 0, cyc = 0;
	logic [3:0] fn_tab [6] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
	logic [9:0] m_tab [6] = '{10'h020, 10'h010, 10'h040, 10'h008, 10'h004, 10'h001};

	always #25 clk_i = ~clk_i;

	contact_src u_src (.clk_i(clk_i), .first_contact_input_o(c1), .second_contact_input_o(c2),
		.programmable_contact_input_o(c3), .vin_o(vin), .iin_o(iin));
	drive_cmd u_dut (.clk_i(clk_i), .rst_i(rst_i), .first_contact_input_i(c1),
		.second_contact_input_i(c2), .programmable_contact_input_i(c3), .vin_i(vin),
		.iin_i(iin), .cmd_o(cmd), .lim_o(lim), .awaddr_i(awaddr), .awvalid_i(awvalid),
		.awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
		.wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
		.araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
		.rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready));

	//----------------------------------------
	// helpers
	//----------------------------------------
	task end_sim();
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			end_sim();
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] exp_ref(input logic [11:0] v, input logic inv);
		logic [31:0] p;
		p = {20'h0, inv ? (`ADC_FULL - v) : v};
		return 16'((p * {16'h0, `FMAX_RST}) >> 12);
	endfunction
	function automatic logic [31:0] cfg(input logic [2:0] s, input logic [3:0] f,
		input logic [2:0] src);
		return {22'h0, src, f, s};
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
			err_count++;
		end
	endtask
	task cc(input logic [9:0] m, input logic [9:0] e);
		chk("cmd", {22'h0, e}, {22'h0, cmd & m});
	endtask
	task cs(input logic [2:0] c);
		u_src.set_c(c, 0);
		repeat (5) @(posedge clk_i);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task adc(input logic [11:0] v, input logic [11:0] i);
		u_src.set_adc(v, i);
		repeat (5) @(posedge clk_i);
	endtask

	//----------------------------------------
	// main sequence
	//----------------------------------------
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`A_FMAX);
		chk("fmax", 32'h000001F4, d);
		rd(8'h40);
		chk("resp", {30'h0, `RESP_ERR}, {30'h0, r});
		wr(8'h40, 32'h0);
		chk("bresp", {30'h0, `RESP_ERR}, {30'h0, r});
		wr(`A_VSPAN, 32'hFFFFFFFF);
		chk("bresp", {30'h0, `RESP_OK}, {30'h0, r});
		rd(`A_VSPAN);
		chk("vspan", 32'h0FFF0000, d);
		wr(`A_CTRL, cfg(3'h0, 4'h0, 3'h1));
		cs(3'b001);
		cc(RUN | REV, RUN);
		cs(3'b011);
		cc(RUN | REV, RUN);
		cs(3'b010);
		cc(RUN | REV, RUN | REV);
		cs(3'b000);
		cc(RUN, 10'h0);
		cs(3'b011);
		cc(RUN | REV, RUN);
		wr(`A_CTRL, cfg(3'h1, 4'h0, 3'h1));
		repeat (8)
		begin
			rnd = lfsr(rnd);
			u_src.set_c({1'b0, rnd[1:0]}, int'(rnd[3:2]));
			repeat (8) @(posedge clk_i);
			cc(RUN | REV, {rnd[0], rnd[1], 8'h0});
		end
		cs(3'b000);
		wr(`A_CTRL, cfg(3'h2, 4'h0, 3'h1));
		cs(3'b001);
		cc(RUN, 10'h0);
		cs(3'b011);
		cc(RUN, RUN);
		cs(3'b000);
		wr(`A_CTRL, cfg(3'h3, 4'h5, 3'h1));
		cs(3'b001);
		cs(3'b000);
		cc(RUN, RUN);
		cs(3'b100);
		cc(REV, REV);
		cs(3'b110);
		cc(RUN, 10'h0);
		wr(`A_CTRL, cfg(3'h4, 4'h0, 3'h1));
		cs(3'b011);
		cc(RUN | REV | UP, RUN | UP);
		cs(3'b000);
		wr(`A_CTRL, cfg(3'h0, 4'h0, `SRC_MPOT));
		cs(3'b010);
		cc(REV | UP, UP);
		for (int k = 0; k < 6; k++)
		begin
			wr(`A_CTRL, cfg(3'h0, fn_tab[k], 3'h1));
			cs(3'b100);
			cc(m_tab[k], m_tab[k]);
			cs(3'b000);
			cc(m_tab[k], 10'h0);
		end
		wr(`A_CTRL, cfg(3'h0, 4'h3, 3'h1));
		cs(3'b001);
		cc(RUN, 10'h0);
		cs(3'b101);
		cc(RUN, RUN);
		cs(3'b000);
		wr(`A_CTRL, cfg(3'h0, 4'h1, 3'h1));
		cs(3'b101);
		cc(RUN | FLT, FLT);
		cs(3'b001);
		wr(`A_STATUS, 32'h1);
		cs(3'b000);
		cc(FLT, 10'h0);
		wr(`A_CTRL, cfg(3'h0, 4'h2, 3'h1));
		cs(3'b100);
		cc(FLT, FLT);
		wr(`A_STATUS, 32'h1);
		cc(FLT, 10'h0);
		cs(3'b000);
		cc(FLT, FLT);
		cs(3'b100);
		wr(`A_STATUS, 32'h1);
		for (int k = 0; k < 8; k++)
		begin
			rnd = lfsr(rnd);
			wr(`A_CTRL, cfg(3'h0, 4'h0, 3'h1) | {18'h0, rnd[15], 13'h0});
			adc(rnd[11:0], 12'h000);
			chk("ref", {16'h0, exp_ref(rnd[11:0], rnd[15])}, {16'h0, lim.ref_val});
		end
		wr(`A_CTRL, cfg(3'h0, 4'h0, 3'h0) | 32'h00000800);
		adc(12'h000, `ADC_4MA);
		chk("ref", 32'h0, {16'h0, lim.ref_val});
		adc(12'h000, `ADC_FULL);
		chk("ref", {16'h0, exp_ref(`ADC_FULL, 1'b0)}, {16'h0, lim.ref_val});
		adc(12'h400, 12'h000);
		wr(`A_CAP, 32'h1);
		adc(12'hC00, 12'h000);
		wr(`A_CAP, 32'h2);
		rd(`A_VSPAN);
		chk("vspan", 32'h0C000400, d);
		wr(`A_CTRL, cfg(3'h0, 4'h0, 3'h1) | 32'h00000400);
		adc(12'hC00, 12'h000);
		chk("ref", {16'h0, exp_ref(`ADC_FULL, 1'b0)}, {16'h0, lim.ref_val});
		adc(12'h400, 12'h000);
		chk("ref", 32'h0, {16'h0, lim.ref_val});
		wr(`A_CTRL, cfg(3'h0, 4'h0, 3'h1));
		wr(`A_SCALE_B, {16'd200, 16'd300});
		adc(`ADC_FULL, 12'h000);
		chk("ref", {16'h0, exp_ref(`ADC_FULL, 1'b0)}, {16'h0, lim.ref_val});
		wr(`A_SCALE_B, {16'd400, 16'd100});
		adc(`ADC_FULL, 12'h000);
		chk("ref", 32'd399, {16'h0, lim.ref_val});
		wr(`A_LIM0, {16'd800, 16'd1000});
		wr(`A_LIM1, {16'd600, 16'd1000});
		adc(12'hC00, 12'h000);
		chk("cur", 32'd1000, {16'h0, lim.cur_lim});
		wr(`A_CTRL, {12'h0, 3'h3, 2'h1, 15'h0});
		adc(12'hC00, 12'h000);
		chk("ramp", 32'd4, {29'h0, lim.ramp_div});
		wr(`A_CTRL, {12'h0, 3'h1, 2'h1, 15'h0});
		adc(12'h000, 12'h000);
		chk("cur", 32'd0, {16'h0, lim.cur_lim});
		wr(`A_CTRL, {12'h0, 3'h2, 2'h1, 15'h0});
		adc(12'h000, 12'h000);
		chk("brk", 32'd150, {16'h0, lim.brk_cur});
		wr(`A_CTRL, {12'h0, 3'h4, 2'h1, 15'h0});
		adc(12'h000, 12'h000);
		chk("trq", 32'd0, {16'h0, lim.trq_lim});
		end_sim();
	end
endmodule
